// ==== design/synth_control_consts.svh ====
`ifndef SYNTH_CONTROL_CONSTS_SVH
`define SYNTH_CONTROL_CONSTS_SVH

// serial word framing
`define WORD_BITS 24
`define SEL_LSB 0
`define SEL_MSB 1
`define SEL_REF 2'h0
`define SEL_AB 2'h1
`define SEL_FUNC 2'h2
`define SEL_INIT 2'h3

// function / initialization latch field positions
`define F_COUNTER_RESET 2
`define F_PD_REQUEST 3
`define F_MON_LSB 4
`define F_MON_MSB 6
`define F_POLARITY 7
`define F_PUMP_OFF 8
`define F_FAST_EN 9
`define F_FAST_MODE 10
`define F_TC_LSB 11
`define F_TC_MSB 14
`define F_CUR1_LSB 15
`define F_CUR1_MSB 17
`define F_CUR2_LSB 18
`define F_CUR2_MSB 20
`define F_PD_SYNC 21
`define F_PRE_LSB 22
`define F_PRE_MSB 23

// AB counter latch boost-current bit
`define AB_BOOST_BIT 21

// reset values
`define FUNC_RESET 24'h000000
`define AB_RESET 24'h000000
`define REF_RESET 24'h000000

`endif

// ==== design/synth_control_pkg.sv ====
package synth_control_pkg;

  typedef enum logic [1:0]
  {
    FL_OFF = 2'b00,
    FL_MANUAL = 2'b01,
    FL_TIMED = 2'b10
  } fastlock_state_t;

  typedef logic [23:0] latch_word_t;

endpackage : synth_control_pkg

// ==== design/synth_control_latches.sv ====
`timescale 1ns/1ps
`include "synth_control_consts.svh"

// Behaviour
// - word bits 1:0 select latch; 00 reference latch, 01 AB latch.
// - select bits 10 store the word into the function latch.
// - select bits 11 store function settings and pulse counter reset.
// - counter-reset bit two set holds reference and AB counters reset.
// - on counter reset release, N counter restarts aligned with reference counter.
// - chip-enable low disables the device regardless of power-down bits.
// - power-down bit with sync-select zero powers down right after latching.
// - power-down bit with sync-select one waits for next charge pump event.
// - any power-down loads counters, three-states pump, resets clock detect.
// - serial register keeps accepting and latching words during power-down.
// - three-bit selector picks the signal driving the monitor output pin.
// - function bit nine enables fastlock; no fastlock while it is zero.
// - function bit ten picks fastlock mode: zero manual, one timed.
// - mode 1 boost bit one selects current setting 2, zero returns.
// - mode 2 timeout expiry clears boost bit and reverts to setting 1.
// - timeout counter runs only when fastlock mode 2 is selected.
// - lower three-bit field is current setting 1, upper is setting 2.
// - one function bit sets phase detector polarity.
// - pump-output disable bit one puts charge pump in high impedance.
// - initialization word programming power-down triggers it with its reset pulse.
// - first AB load after initialization repeats reset pulse; later ones do not.
module synth_control_latches
  import synth_control_pkg::*;
#(
  parameter int TIMER_W = 8,
  parameter int MON_SOURCES = 8,
  parameter logic [16*TIMER_W-1:0] TIMEOUT_LUT = {
    8'h3f, 8'h3b, 8'h37, 8'h33, 8'h2f, 8'h2b, 8'h27, 8'h23,
    8'h1f, 8'h1b, 8'h17, 8'h13, 8'h0f, 8'h0b, 8'h07, 8'h03
  }
)
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic serClk,
  input wire logic serData,
  input wire logic latchEnable,
  input wire logic chipEnable,
  input wire logic refTick,
  input wire logic pumpEvent,
  input wire logic [MON_SOURCES-1:0] monitorSources,
  output logic counterReset,
  output logic internalResetPulse,
  output logic counterRelease,
  output logic powerDown,
  output logic clockDetectReset,
  output logic pumpHighZ,
  output logic [2:0] pumpCurrent,
  output logic boostActive,
  output logic monitorOutputPin,
  output logic phaseDetectPolarity,
  output logic [1:0] prescalerSelect,
  output logic [23:0] refWord,
  output logic refLoad,
  output logic [23:0] abWord,
  output logic abLoad
);

  function automatic logic selIs(input logic [1:0] sel, input logic [1:0] code);
    selIs = (sel == code);
  endfunction : selIs

  function automatic logic [TIMER_W-1:0] timeoutCount(input logic [3:0] code);
    timeoutCount = TIMEOUT_LUT[code*TIMER_W +: TIMER_W];
  endfunction : timeoutCount

  // link domain: shift register clocked by the serial clock, no gating by power-down
  latch_word_t shiftReg_q;

  always_ff @(posedge serClk)
  begin
    shiftReg_q <= {shiftReg_q[22:0], serData};
  end

  // pin synchronisers: latch enable and chip enable
  // only the second flop of each pair feeds logic
  localparam int N_SYNC = 2;
  logic [N_SYNC-1:0] pinIn;
  logic [N_SYNC-1:0] syncMeta_q;
  logic [N_SYNC-1:0] syncOut_q;

  assign pinIn = {chipEnable, latchEnable};

  genvar gi;
  generate
    for (gi = 0; gi < N_SYNC; gi++)
    begin : g_sync
      always_ff @(posedge mclk)
      begin
        if (sys_rst)
        begin
          syncMeta_q[gi] <= 1'b0;
          syncOut_q[gi] <= 1'b0;
        end
        else
        begin
          syncMeta_q[gi] <= pinIn[gi];
          syncOut_q[gi] <= syncMeta_q[gi];
        end
      end
    end
  endgenerate

  logic leLast_q;
  wire leSync = syncOut_q[0];
  wire ceSync = syncOut_q[1];
  // shift register is frozen while latch enable is high, so it is safe to sample here
  wire leRise = leSync & ~leLast_q;

  // word decode
  // select bits are shifted in last and sit at the bottom of the word
  wire [1:0] latchSel = shiftReg_q[`SEL_MSB:`SEL_LSB];
  wire loadRef = leRise & selIs(latchSel, `SEL_REF);
  wire loadAb = leRise & selIs(latchSel, `SEL_AB);
  wire loadFunc = leRise & selIs(latchSel, `SEL_FUNC);
  wire loadInit = leRise & selIs(latchSel, `SEL_INIT);
  wire loadSettings = loadFunc | loadInit;
  wire newPdReq = shiftReg_q[`F_PD_REQUEST];
  wire newPdSync = shiftReg_q[`F_PD_SYNC];
  wire newBoost = shiftReg_q[`AB_BOOST_BIT];

  // function latch
  latch_word_t funcLatch_q;
  latch_word_t funcLatch_d;
  assign funcLatch_d = loadSettings ? shiftReg_q : funcLatch_q;

  wire fCounterReset = funcLatch_d[`F_COUNTER_RESET];
  wire [2:0] fMonSel = funcLatch_q[`F_MON_MSB:`F_MON_LSB];
  wire fPolarity = funcLatch_d[`F_POLARITY];
  wire fPumpOff = funcLatch_d[`F_PUMP_OFF];
  wire fFastEn = funcLatch_q[`F_FAST_EN];
  wire fFastMode = funcLatch_q[`F_FAST_MODE];
  wire [3:0] fTimeout = funcLatch_q[`F_TC_MSB:`F_TC_LSB];
  wire [2:0] fCur1 = funcLatch_q[`F_CUR1_MSB:`F_CUR1_LSB];
  wire [2:0] fCur2 = funcLatch_q[`F_CUR2_MSB:`F_CUR2_LSB];
  wire [1:0] fPrescaler = funcLatch_d[`F_PRE_MSB:`F_PRE_LSB];

  // programmed power-down
  // a synchronous request waits in syncPending_q for the next pump event
  logic pdActive_q;
  logic pdActive_d;
  logic syncPending_q;
  logic syncPending_d;

  always_comb
  begin
    pdActive_d = pdActive_q;
    syncPending_d = syncPending_q;
    if (loadSettings)
    begin
      if (!newPdReq)
      begin
        pdActive_d = 1'b0;
        syncPending_d = 1'b0;
      end
      else if (loadInit && ceSync)
      begin
        pdActive_d = 1'b1;
        syncPending_d = 1'b0;
      end
      else if (!newPdSync)
      begin
        pdActive_d = 1'b1;
        syncPending_d = 1'b0;
      end
      else if (!pdActive_q)
      begin
        // a request already pending still takes this cycle's pump event
        pdActive_d = syncPending_q & pumpEvent;
        syncPending_d = ~(syncPending_q & pumpEvent);
      end
    end
    else if (syncPending_q && pumpEvent)
    begin
      pdActive_d = 1'b1;
      syncPending_d = 1'b0;
    end
  end

  // chip enable low overrides whatever the latch asks for
  wire pdNext = pdActive_d | ~ceSync;

  // internal reset pulse and its re-arm after initialization
  logic abArm_q;
  wire abArm_d = loadInit ? 1'b1 : (loadAb ? 1'b0 : abArm_q);
  wire resetPulse_d = loadInit | (loadAb & abArm_q);
  // counters and pump are held while any reset or power-down is in force
  wire counterReset_d = fCounterReset | pdNext | resetPulse_d;
  wire counterRelease_d = counterReset & ~counterReset_d;
  wire pumpHighZ_d = fPumpOff | pdNext | counterReset_d;

  // fastlock controller
  // the mode is taken when boosting starts and kept until it ends
  fastlock_state_t flState_q;
  fastlock_state_t flState_d;
  logic [TIMER_W-1:0] timer_q;
  logic [TIMER_W-1:0] timer_d;
  // expiry is the tick that would take the count to zero; a new AB load takes precedence
  wire timerExpire = (flState_q == FL_TIMED) & refTick & (timer_q <= TIMER_W'(1)) &
    ~pdNext & ~loadAb;

  always_comb
  begin
    flState_d = flState_q;
    case (flState_q)
      FL_OFF:
      begin
        if (loadAb && newBoost && fFastEn)
        begin
          flState_d = fFastMode ? FL_TIMED : FL_MANUAL;
        end
      end
      FL_MANUAL:
      begin
        if ((loadAb && !newBoost) || !fFastEn)
        begin
          flState_d = FL_OFF;
        end
      end
      FL_TIMED:
      begin
        if (timerExpire || (loadAb && !newBoost) || !fFastEn)
        begin
          flState_d = FL_OFF;
        end
      end
      default:
      begin
        flState_d = FL_OFF;
      end
    endcase
  end

  // the timer reloads whenever it is not timing, so each boost gets a full period
  always_comb
  begin
    if (pdNext || resetPulse_d || flState_q != FL_TIMED)
    begin
      timer_d = timeoutCount(fTimeout);
    end
    else if (loadAb && newBoost)
    begin
      // a fresh boost write restarts the timeout
      timer_d = timeoutCount(fTimeout);
    end
    else if (refTick && timer_q != '0)
    begin
      timer_d = timer_q - TIMER_W'(1);
    end
    else
    begin
      timer_d = timer_q;
    end
  end

  // current setting 2 is in force for the whole boost
  wire boost_d = (flState_d != FL_OFF);
  wire [2:0] pumpCurrent_d = boost_d ? fCur2 : fCur1;

  // AB word: boost bit is cleared by the timer on expiry
  // a new AB load in the expiry cycle wins over the clear
  latch_word_t abWord_d;
  always_comb
  begin
    abWord_d = abWord;
    if (loadAb)
    begin
      abWord_d = shiftReg_q;
    end
    else if (timerExpire)
    begin
      abWord_d[`AB_BOOST_BIT] = 1'b0;
    end
  end

  wire refWordSel = loadRef;
  // monitor follows the stored selector, one cycle behind the latch
  wire monitor_d = monitorSources[fMonSel];

  // control registers
  // leLast_q holds the previous synchronised latch enable for edge detection
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      leLast_q <= 1'b0;
      funcLatch_q <= `FUNC_RESET;
      pdActive_q <= 1'b0;
      syncPending_q <= 1'b0;
      abArm_q <= 1'b0;
      flState_q <= FL_OFF;
      timer_q <= '0;
    end
    else
    begin
      leLast_q <= leSync;
      funcLatch_q <= funcLatch_d;
      pdActive_q <= pdActive_d;
      syncPending_q <= syncPending_d;
      abArm_q <= abArm_d;
      flState_q <= flState_d;
      timer_q <= timer_d;
    end
  end

  // registered outputs
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      counterReset <= 1'b1;
      internalResetPulse <= 1'b0;
      counterRelease <= 1'b0;
      powerDown <= 1'b1;
      clockDetectReset <= 1'b1;
      pumpHighZ <= 1'b1;
      pumpCurrent <= 3'h0;
      boostActive <= 1'b0;
      monitorOutputPin <= 1'b0;
      phaseDetectPolarity <= 1'b0;
      prescalerSelect <= 2'h0;
    end
    else
    begin
      counterReset <= counterReset_d;
      internalResetPulse <= resetPulse_d;
      counterRelease <= counterRelease_d;
      powerDown <= pdNext;
      clockDetectReset <= pdNext;
      pumpHighZ <= pumpHighZ_d;
      pumpCurrent <= pumpCurrent_d;
      boostActive <= boost_d;
      monitorOutputPin <= monitor_d;
      phaseDetectPolarity <= fPolarity;
      prescalerSelect <= fPrescaler;
    end
  end

  // counter latch words handed to the dividers
  // load strobes last one cycle and travel with their words
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      refWord <= `REF_RESET;
      refLoad <= 1'b0;
      abWord <= `AB_RESET;
      abLoad <= 1'b0;
    end
    else
    begin
      if (refWordSel)
      begin
        refWord <= shiftReg_q;
      end
      refLoad <= loadRef;
      abWord <= abWord_d;
      abLoad <= loadAb;
    end
  end

endmodule : synth_control_latches

// ==== testbench/synth_control_chk.sv ====
`timescale 1ns/1ps
module synth_control_chk
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic chipEnable,
  input wire logic counterReset,
  input wire logic internalResetPulse,
  input wire logic counterRelease,
  input wire logic powerDown,
  input wire logic clockDetectReset,
  input wire logic pumpHighZ,
  input wire logic refLoad,
  input wire logic abLoad
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);

  AST_CE_OFF: assert property (!chipEnable [*4] |-> powerDown)
    else $error("no power down with chip enable low");
  AST_CLK_DET: assert property (clockDetectReset == powerDown)
    else $error("clock detect reset differs from power down");
  AST_PD_EFFECT: assert property (powerDown |-> pumpHighZ && counterReset)
    else $error("power down without pump and counter hold");
  AST_RELEASE: assert property (counterRelease |-> !counterReset && $past(counterReset))
    else $error("release pulse without counter reset fall");
  AST_INIT_PULSE: assert property (internalResetPulse |=> !internalResetPulse)
    else $error("reset pulse longer than one cycle");
  AST_INIT_HOLD: assert property (internalResetPulse |-> counterReset)
    else $error("reset pulse without counter reset");
  AST_ONE_LATCH: assert property (!(refLoad && abLoad))
    else $error("two latches loaded from one word");
  AST_LOAD_PULSE: assert property ((refLoad || abLoad) |=> !(refLoad || abLoad))
    else $error("load strobe longer than one cycle");
endmodule : synth_control_chk

bind synth_control_latches synth_control_chk i_chk
(
  .mclk, .sys_rst, .chipEnable, .counterReset, .internalResetPulse, .counterRelease,
  .powerDown, .clockDetectReset, .pumpHighZ, .refLoad, .abLoad
);

// ==== testbench/serial_host_model.sv ====
`timescale 1ns/1ps
module serial_host_model
(
  output logic serClk,
  output logic serData,
  output logic latchEnable
);
  initial
  begin
    serClk = 1'b0;
    serData = 1'b0;
    latchEnable = 1'b0;
  end

  // msb first so the select bits arrive last; clock stands still between frames
  task send(input logic [23:0] word);
    for (int i = 23; i >= 0; i--)
    begin
      serData = word[i];
      #3 serClk = 1'b1;
      #3 serClk = 1'b0;
    end
    serData = ~serData;
    #10 latchEnable = 1'b1;
    #150 latchEnable = 1'b0;
    #160;
  endtask : send
endmodule : serial_host_model

// ==== testbench/tb_synth_control_latches.sv ====
`timescale 1ns/1ps
module tb_synth_control_latches;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic chipEnable = 1'b1;
  logic refTick = 1'b0;
  logic pumpEvent = 1'b0;
  logic [7:0] monitorSources = 8'h5a;
  logic serClk, serData, latchEnable, counterReset, internalResetPulse, counterRelease;
  logic powerDown, clockDetectReset, pumpHighZ, boostActive, monitorOutputPin;
  logic phaseDetectPolarity, refLoad, abLoad;
  logic [2:0] pumpCurrent;
  logic [1:0] prescalerSelect;
  logic [23:0] refWord, abWord;
  logic [47:0] pulses = 48'h0;
  logic [47:0] releases = 48'h0;
  int badCount = 0;
  int compares = 0;
  // function word beside {polarity, prescaler, current, high-z, monitor}
  logic [31:0] rows [8] = '{32'h02800214, 32'h410092a9, 32'h8381225e, 32'hc0003261,
    32'h0080c285, 32'h00005200, 32'h00006201, 32'h03007218};
  wire [7:0] fnOut = {phaseDetectPolarity, prescalerSelect, pumpCurrent, pumpHighZ,
    monitorOutputPin};
  wire [47:0] fastOut = {43'h0, boostActive, pumpCurrent, abWord[21]};

  always #25 mclk = ~mclk;

  always @(negedge mclk)
  begin
    if (internalResetPulse === 1'b1)
      pulses++;
    if (counterRelease === 1'b1)
      releases++;
  end

  serial_host_model i_host (.serClk, .serData, .latchEnable);

  synth_control_latches i_dut
  (
    .mclk, .sys_rst, .serClk, .serData, .latchEnable, .chipEnable, .refTick, .pumpEvent,
    .monitorSources, .counterReset, .internalResetPulse, .counterRelease, .powerDown,
    .clockDetectReset, .pumpHighZ, .pumpCurrent, .boostActive, .monitorOutputPin,
    .phaseDetectPolarity, .prescalerSelect, .refWord, .refLoad, .abWord, .abLoad
  );

  task check(input logic [47:0] got, input logic [47:0] exp);
    compares++;
    if (got !== exp)
    begin
      badCount++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task finish_test;
    $display("compares %0d mismatches %0d", compares, badCount);
    if (badCount == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test

  task send(input logic [23:0] w);
    @(posedge mclk) #2;
    i_host.send(w);
  endtask : send

  task automatic pulse(ref logic s, input int n);
    repeat (n)
    begin
      @(posedge mclk) #2 s = 1'b1;
      @(posedge mclk) #2 s = 1'b0;
    end
    repeat (2) @(posedge mclk);
    #2;
  endtask : pulse

  initial
  begin
    repeat (6) @(posedge mclk);
    #2 check(48'({counterReset, powerDown, pumpHighZ, boostActive, refLoad}), 48'h1c);
    sys_rst = 1'b0;
    repeat (4) @(posedge mclk);
    foreach (rows[k])
    begin
      send(rows[k][31:8]);
      check(48'(fnOut), 48'(rows[k][7:0]));
    end
    send(24'h000006);
    check(48'({counterReset, pumpHighZ}), 48'h3);
    send(24'h000a00);
    send(24'h000101);
    send(24'h000002);
    check({counterReset, refWord, abWord[22:0]}, {1'b0, 24'h000a00, 23'h000101});
    check(releases, 48'h2);
    send(24'h000003);
    check(pulses, 48'h1);
    send(24'h000101);
    send(24'h000201);
    check(pulses, 48'h2);
    send(24'h00000a);
    check(48'(powerDown), 48'h1);
    send(24'h000b00);
    check(48'(refWord), 48'h000b00);
    send(24'h200002);
    send(24'h20000a);
    check(48'(powerDown), 48'h0);
    pulse(pumpEvent, 1);
    check(48'(powerDown), 48'h1);
    send(24'h000002);
    send(24'h20000b);
    check(48'(powerDown), 48'h1);
    send(24'h000002);
    @(posedge mclk) #2 chipEnable = 1'b0;
    repeat (4) @(posedge mclk);
    #2 check(48'({powerDown, clockDetectReset}), 48'h3);
    chipEnable = 1'b1;
    repeat (4) @(posedge mclk);
    #2 check(48'(powerDown), 48'h0);
    send(24'h188202);
    send(24'h200001);
    pulse(refTick, 4);
    check(fastOut, 48'h1d);
    send(24'h000001);
    check(fastOut, 48'h02);
    send(24'h188002);
    send(24'h200001);
    check(fastOut, 48'h03);
    send(24'h188602);
    send(24'h200001);
    pulse(refTick, 2);
    check(fastOut, 48'h1d);
    pulse(refTick, 1);
    check(fastOut, 48'h02);
    @(posedge mclk) #2 sys_rst = 1'b1;
    repeat (3) @(posedge mclk);
    #2 check(48'({counterReset, powerDown, pumpHighZ, boostActive, abWord}), 48'he000000);
    sys_rst = 1'b0;
    repeat (4) @(posedge mclk);
    #2 check(48'({counterReset, powerDown, pumpHighZ, boostActive}), 48'h0);
    finish_test();
  end

  initial
  begin
    #100000;
    badCount++;
    finish_test();
  end
endmodule : tb_synth_control_latches
